/* File: common/irq_prio_consts.svh */
/*
 * offsets, field masks, reset values and sizes of the source priority block.
 * assumes 32-bit aligned apb addresses; the package holds the types.
 */
`ifndef IRQ_PRIO_CONSTS_SVH
`define IRQ_PRIO_CONSTS_SVH

`define SPR_A_ADDR      32'hffff0024
`define SPR_B_ADDR      32'hffff0028
`define SPR_C_ADDR      32'hffff002c
`define NEST_CTRL_ADDR  32'hffff0030
`define NORM_INSV_ADDR  32'hffff003c
`define NORM_VEC_ADDR   32'hffff0040
`define FAST_VEC_ADDR   32'hffff0044

`define SPR_A_MASK      32'h00007777
`define SPR_B_MASK      32'h77777777
`define SPR_C_MASK      32'h00000077
`define NEST_CTRL_MASK  32'h00000003
`define NORM_INSV_MASK  32'h000000ff
`define REG_RESET       32'h00000000

`define NEST_NORM_BIT   0
`define NEST_FAST_BIT   1
`define VEC_VALID_BIT   31
`define SRC_COUNT       14
`define LEVEL_COUNT     8

`endif

/* File: common/irq_prio_pkg.sv */
/*
 * types shared by the priority register block and its arbiter.
 * assumes irq_prio_consts.svh for the source and level counts.
 */
`include "irq_prio_consts.svh"

package irq_prio_pkg;
   typedef logic [2:0]                 prio_t;
   typedef prio_t [`SRC_COUNT-1:0]     prio_vec_t;
   typedef logic [`SRC_COUNT-1:0]      src_mask_t;
   typedef logic [`LEVEL_COUNT-1:0]    level_mask_t;
   typedef struct packed {
      logic       valid;
      logic [3:0] src;
      prio_t      prio;
   } arb_result_t;
endpackage : irq_prio_pkg

/* File: design/source_arbiter.sv */
/*
 * combinational pick of the winning source of one request class.
 * assumes pending bits already enabled and on the same clock as its user.
 */
`timescale 1ns/1ps
`include "irq_prio_consts.svh"

module source_arbiter (
   input  wire irq_prio_pkg::src_mask_t   pend,
   input  wire irq_prio_pkg::prio_vec_t   prio,
   input  wire logic                      nest_en,
   input  wire irq_prio_pkg::level_mask_t in_service,
   output irq_prio_pkg::arb_result_t      result
);
   import irq_prio_pkg::*;

   prio_t eff_prio;
   logic  blocked;

   always_comb begin
      result   = '0;
      eff_prio = '0;
      blocked  = 1'b0;
      for (int i = 0; i < `SRC_COUNT; i++) begin
         // levels only count with nesting on; otherwise lowest index wins
         eff_prio = nest_en ? prio[i] : 3'h0;
         blocked  = 1'b0;
         for (int k = 0; k < `LEVEL_COUNT; k++) begin
            if (in_service[k] && (3'(k) <= eff_prio)) begin
               blocked = nest_en;
            end
         end
         // strict less-than keeps the lowest index on a tie; 0 is most urgent
         if (pend[i] && !blocked && (!result.valid || eff_prio < result.prio)) begin
            result.valid = 1'b1;
            result.src   = 4'(i);
            result.prio  = eff_prio;
         end
      end
   end
endmodule : source_arbiter

/* File: design/irq_prio_regs.sv */
/*
 * per-source priority registers of the vectored interrupt controller,
 * apb slave, normal in-service tracking and normal/fast request outputs.
 * assumes pending inputs come from enabled source logic on sys_clk.
 */
`timescale 1ns/1ps
`include "irq_prio_consts.svh"

module irq_prio_regs (
   input  wire logic                     sys_clk,
   input  wire logic                     rst_n,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [31:0]              paddr,
   input  wire logic [31:0]              pwdata,
   output logic [31:0]                   prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire irq_prio_pkg::src_mask_t  irq_pend,
   input  wire irq_prio_pkg::src_mask_t  fiq_pend,
   output logic                          irq_out,
   output logic                          fiq_out,
   output irq_prio_pkg::arb_result_t     irq_sel,
   output irq_prio_pkg::level_mask_t     in_service
);
   import irq_prio_pkg::*;

   logic [1:0]  rst_sync_ff;
   logic        sys_rst_n;
   logic [31:0] spr_a_ff;
   logic [31:0] spr_b_ff;
   logic [31:0] spr_c_ff;
   logic [1:0]  nest_ctrl_ff;
   level_mask_t insv_ff;
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;
   logic        irq_out_ff;
   logic        fiq_out_ff;
   arb_result_t irq_sel_ff;
   arb_result_t vec_hold_ff;
   prio_vec_t   prio_vec;
   arb_result_t norm_res;
   arb_result_t fast_res;
   logic [55:0] nibbles;
   logic        setup;
   logic        access;
   logic        wr_acc;
   logic        vec_rd;
   level_mask_t insv_low;
   logic [31:0] nxt_prdata;
   logic        nxt_err;

   // reset released through two flops, asserted at once
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign sys_rst_n = rst_sync_ff[1];

   assign setup  = psel && !penable;
   assign access = psel && penable && pready_ff;
   assign wr_acc = access && pwrite;
   assign vec_rd = access && !pwrite && (paddr == `NORM_VEC_ADDR);

   // every field sits in its own nibble; gather them in source order
   assign nibbles = {spr_c_ff[7:0], spr_b_ff, spr_a_ff[15:0]};

   genvar gi;
   generate
      for (gi = 0; gi < `SRC_COUNT; gi++) begin : g_field
         assign prio_vec[gi] = nibbles[4*gi +: 3];
      end
   endgenerate

   source_arbiter u_norm_arb (
      .pend       (irq_pend),
      .prio       (prio_vec),
      .nest_en    (nest_ctrl_ff[`NEST_NORM_BIT]),
      .in_service (insv_ff),
      .result     (norm_res)
   );

   // the fast class keeps no in-service state of its own here
   source_arbiter u_fast_arb (
      .pend       (fiq_pend),
      .prio       (prio_vec),
      .nest_en    (nest_ctrl_ff[`NEST_FAST_BIT]),
      .in_service (8'h00),
      .result     (fast_res)
   );

   // priority words; masks keep reserved bits at zero
   always_ff @(posedge sys_clk or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         spr_a_ff <= `REG_RESET;
         spr_b_ff <= `REG_RESET;
         spr_c_ff <= `REG_RESET;
      end else if (wr_acc) begin
         if (paddr == `SPR_A_ADDR) begin
            spr_a_ff <= pwdata & `SPR_A_MASK;
         end
         if (paddr == `SPR_B_ADDR) begin
            spr_b_ff <= pwdata & `SPR_B_MASK;
         end
         if (paddr == `SPR_C_ADDR) begin
            spr_c_ff <= pwdata & `SPR_C_MASK;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         nest_ctrl_ff <= 2'h0;
      end else if (wr_acc && paddr == `NEST_CTRL_ADDR) begin
         nest_ctrl_ff <= pwdata[1:0];
      end
   end

   // only the most urgent set bit may be cleared, one per write
   assign insv_low = insv_ff & 8'(~insv_ff + 8'h01);

   always_ff @(posedge sys_clk or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         insv_ff <= '0;
      end else if (vec_rd && vec_hold_ff.valid && nest_ctrl_ff[`NEST_NORM_BIT]) begin
         insv_ff[vec_hold_ff.prio] <= 1'b1;
      end else if (wr_acc && paddr == `NORM_INSV_ADDR && |(insv_low & pwdata[7:0])) begin
         insv_ff <= insv_ff & ~insv_low;
      end
   end

   // read mux, sampled in the setup cycle so the access cycle answers at once
   always_comb begin
      nxt_prdata = 32'h0;
      nxt_err    = 1'b0;
      unique case (paddr)
         `SPR_A_ADDR:     nxt_prdata = spr_a_ff;
         `SPR_B_ADDR:     nxt_prdata = spr_b_ff;
         `SPR_C_ADDR:     nxt_prdata = spr_c_ff;
         `NEST_CTRL_ADDR: nxt_prdata = {30'h0, nest_ctrl_ff};
         `NORM_INSV_ADDR: nxt_prdata = {24'h0, insv_ff};
         `NORM_VEC_ADDR:  nxt_prdata = {norm_res.valid, 24'h0, norm_res.src, norm_res.prio};
         `FAST_VEC_ADDR:  nxt_prdata = {fast_res.valid, 24'h0, fast_res.src, fast_res.prio};
         default:         nxt_err    = 1'b1;
      endcase
   end

   always_ff @(posedge sys_clk or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         pready_ff   <= 1'b0;
         pslverr_ff  <= 1'b0;
         prdata_ff   <= 32'h0;
         vec_hold_ff <= '0;
      end else begin
         pready_ff  <= setup;
         pslverr_ff <= setup && nxt_err;
         if (setup) begin
            prdata_ff   <= pwrite ? 32'h0 : nxt_prdata;
            vec_hold_ff <= norm_res;
         end
      end
   end

   // fast requests always win over normal ones
   always_ff @(posedge sys_clk or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         irq_out_ff <= 1'b0;
         fiq_out_ff <= 1'b0;
         irq_sel_ff <= '0;
      end else begin
         fiq_out_ff <= fast_res.valid;
         irq_out_ff <= norm_res.valid && !fast_res.valid;
         irq_sel_ff <= norm_res;
      end
   end

   assign prdata     = prdata_ff;
   assign pready     = pready_ff;
   assign pslverr    = pslverr_ff;
   assign irq_out    = irq_out_ff;
   assign fiq_out    = fiq_out_ff;
   assign irq_sel    = irq_sel_ff;
   assign in_service = insv_ff;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!sys_rst_n);

   sequence s_write_b;
      wr_acc && paddr == `SPR_B_ADDR;
   endsequence

   sequence s_vec_taken;
      vec_rd && vec_hold_ff.valid && nest_ctrl_ff[`NEST_NORM_BIT];
   endsequence

   a_resv_bits_zero: assert property (
      (spr_b_ff & ~`SPR_B_MASK) == 32'h0 && (spr_a_ff & ~`SPR_A_MASK) == 32'h0)
      else $error("reserved priority bits not zero");

   a_b_write_lands: assert property (
      s_write_b |=> spr_b_ff == ($past(pwdata) & `SPR_B_MASK))
      else $error("priority word b did not take the write");

   a_pin3_field: assert property (
      prio_vec[11] == spr_b_ff[30:28] && prio_vec[4] == spr_b_ff[2:0])
      else $error("pin 3 or spi level misplaced");

   a_lock_field: assert property (
      prio_vec[3] == spr_a_ff[14:12] && prio_vec[1] == spr_a_ff[6:4])
      else $error("lock or serial level misplaced");

   a_vec_sets_bit: assert property (
      s_vec_taken |=> insv_ff[$past(vec_hold_ff.prio)])
      else $error("vector read did not mark in-service level");

   a_nest_off_no_set: assert property (
      !nest_ctrl_ff[`NEST_NORM_BIT] |=> !$rose(|insv_ff) || $past(nest_ctrl_ff[`NEST_NORM_BIT]))
      else $error("in-service set with nesting off");

   a_fast_beats_norm: assert property (
      fast_res.valid |=> !irq_out_ff && fiq_out_ff)
      else $error("normal request shown over fast one");

   a_blocked_level: assert property (
      nest_ctrl_ff[`NEST_NORM_BIT] && norm_res.valid |-> !insv_ff[0] || norm_res.prio > 3'h7)
      else $error("level 0 in service yet a request passes");

   a_urgent_wins: assert property (
      nest_ctrl_ff[`NEST_NORM_BIT] && norm_res.valid && irq_pend[0] && insv_ff == 8'h00
      |-> norm_res.prio <= prio_vec[0])
      else $error("less urgent source chosen");

   a_pready_pulse: assert property (
      setup |=> pready_ff ##1 !pready_ff || (psel && !penable))
      else $error("pready not a single access cycle");

   sequence s_write_a;
      wr_acc && paddr == `SPR_A_ADDR;
   endsequence

   sequence s_write_c;
      wr_acc && paddr == `SPR_C_ADDR;
   endsequence

   // a clear takes effect only when the write data carries the lowest set bit
   sequence s_clear_taken;
      wr_acc && paddr == `NORM_INSV_ADDR && |(insv_low & pwdata[7:0]);
   endsequence

   sequence s_clear_refused;
      wr_acc && paddr == `NORM_INSV_ADDR && !(|(insv_low & pwdata[7:0]));
   endsequence

   a_serial_b_field: assert property (
      prio_vec[2] == spr_a_ff[10:8] && prio_vec[0] == spr_a_ff[2:0])
      else $error("second serial or converter level misplaced");

   a_pin2_field: assert property (
      prio_vec[10] == spr_b_ff[26:24])
      else $error("pin 2 level misplaced");

   a_logic_req_field: assert property (
      prio_vec[9] == spr_b_ff[22:20])
      else $error("logic-array request level misplaced");

   a_pin1_field: assert property (
      prio_vec[8] == spr_b_ff[18:16])
      else $error("pin 1 level misplaced");

   a_supply_field: assert property (
      prio_vec[7] == spr_b_ff[14:12])
      else $error("supply-monitor level misplaced");

   a_comp_field: assert property (
      prio_vec[6] == spr_b_ff[10:8])
      else $error("comparator level misplaced");

   a_pin0_field: assert property (
      prio_vec[5] == spr_b_ff[6:4])
      else $error("pin 0 level misplaced");

   a_c_fields: assert property (
      prio_vec[12] == spr_c_ff[2:0] && prio_vec[13] == spr_c_ff[6:4])
      else $error("register c levels misplaced");

   a_a_write_lands: assert property (
      s_write_a |=> spr_a_ff == ($past(pwdata) & `SPR_A_MASK))
      else $error("priority word a did not take the write");

   a_c_write_lands: assert property (
      s_write_c |=> spr_c_ff == ($past(pwdata) & `SPR_C_MASK))
      else $error("priority word c did not take the write");

   a_b_holds_else: assert property (
      !(wr_acc && paddr == `SPR_B_ADDR) |=> $stable(spr_b_ff))
      else $error("priority word b changed without a write");

   a_resv_c_zero: assert property (
      (spr_c_ff & ~`SPR_C_MASK) == 32'h0)
      else $error("reserved bits of word c not zero");

   a_nest_off_flat: assert property (
      !nest_ctrl_ff[`NEST_NORM_BIT] && norm_res.valid |-> norm_res.prio == 3'h0)
      else $error("normal level used with nesting off");

   a_nest_off_lowest: assert property (
      !nest_ctrl_ff[`NEST_NORM_BIT] && irq_pend[0] |-> norm_res.valid && norm_res.src == 4'h0)
      else $error("lowest index lost with nesting off");

   a_fast_off_flat: assert property (
      !nest_ctrl_ff[`NEST_FAST_BIT] && fast_res.valid |-> fast_res.prio == 3'h0)
      else $error("fast level used with nesting off");

   a_norm_out_shown: assert property (
      norm_res.valid && !fast_res.valid |=> irq_out_ff && !fiq_out_ff)
      else $error("normal request not shown");

   a_own_level_free: assert property (
      nest_ctrl_ff[`NEST_NORM_BIT] && norm_res.valid |-> !insv_ff[norm_res.prio])
      else $error("winner level already in service");

   a_insv_one_clear: assert property (
      s_clear_taken |=> insv_ff == ($past(insv_ff) & ~$past(insv_low)))
      else $error("in-service clear not lowest single bit");

   a_insv_keeps: assert property (
      s_clear_refused |=> $stable(insv_ff))
      else $error("in-service cleared without its bit");

   // the fast class has no in-service word, so its vector read must leave the normal one alone
   a_fast_no_insv: assert property (
      access && !pwrite && paddr == `FAST_VEC_ADDR |=> $stable(insv_ff))
      else $error("fast vector read touched in-service");

   a_slverr_ready: assert property (
      pslverr_ff |-> pready_ff)
      else $error("slave error outside access cycle");

endmodule : irq_prio_regs

/* File: sim/irq_source_priority_regs_bench.sv */
/*
 * self-checking bench of the source priority block: apb register access, nesting and arbitration.
 * assumes irq_prio_pkg and irq_prio_consts.svh compiled first; assertions live in the design.
 */
`timescale 1ns/1ps
`include "irq_prio_consts.svh"

module irq_source_priority_regs_bench;
   import irq_prio_pkg::*;
   logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq_out, fiq_out;
   logic [31:0] paddr, pwdata, prdata, rd;
   src_mask_t   irq_pend, fiq_pend;
   arb_result_t irq_sel;
   level_mask_t in_service;
   logic        err;
   int          n_fail, total_checks, seed, k;
   logic [31:0] addr_tab [3] = '{`SPR_A_ADDR, `SPR_B_ADDR, `SPR_C_ADDR};
   logic [31:0] mask_tab [3] = '{`SPR_A_MASK, `SPR_B_MASK, `SPR_C_MASK};
   logic [31:0] d;

   irq_prio_regs irq_prio_regs_i (
      .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq_pend(irq_pend), .fiq_pend(fiq_pend), .irq_out(irq_out), .fiq_out(fiq_out),
      .irq_sel(irq_sel), .in_service(in_service));

   initial sys_clk = 1'b0;
   always #5 sys_clk = ~sys_clk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t %s: seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : chk

   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report

   // one apb transfer, entered just after a rising edge; request held until pready is sampled
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      // exactly one access cycle until pready is checked here; only the watchdog ends a missing answer
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1);
      chk(32'(n), 32'h1, "apb wait states");
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb

   // lowest pending index wins when levels are ignored
   function automatic logic [3:0] lowest(input src_mask_t m);
      for (int i = `SRC_COUNT - 1; i >= 0; i--)
         if (m[i]) lowest = 4'(i);
   endfunction : lowest

   task automatic drive_pend(input src_mask_t i_m, input src_mask_t f_m);
      irq_pend <= i_m;
      fiq_pend <= f_m;
      repeat (2) @(posedge sys_clk);
   endtask : drive_pend

   initial begin
      #200000;
      n_fail++;
      final_report();
   end

   initial begin
      seed = 2;
      rst_n = 1'b0;
      {psel, penable, pwrite} = 3'b000;
      paddr = 32'h0;
      pwdata = 32'h0;
      irq_pend = '0;
      fiq_pend = '0;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);

      for (k = 0; k < 3; k++) begin
         apb(1'b0, addr_tab[k], 32'h0);
         chk(rd, `REG_RESET, "reset value");
      end
      $display("test reset values done");

      // random words land only in the level fields; reserved bits read zero
      for (k = 0; k < 24; k++) begin
         d = $random(seed);
         if (k < 3) d = 32'hffffffff;
         apb(1'b1, addr_tab[k % 3], d);
         apb(1'b0, addr_tab[k % 3], 32'h0);
         chk(rd, d & mask_tab[k % 3], "priority readback");
         chk({31'h0, err}, 32'h0, "slave error on mapped");
      end
      apb(1'b1, 32'hffff0020, 32'hffffffff);
      chk({31'h0, err}, 32'h1, "unmapped error");
      apb(1'b0, 32'hffff0020, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      $display("test register access done");

      // nesting off: fast beats normal and the lowest index wins whatever the levels
      for (k = 0; k < 16; k++) begin
         drive_pend(14'($random(seed)), (k % 3 == 0) ? 14'($random(seed)) : 14'h0);
         chk({31'h0, fiq_out}, {31'h0, |fiq_pend}, "fast out");
         chk({31'h0, irq_out}, {31'h0, (|irq_pend) & ~(|fiq_pend)}, "normal out");
         if (|irq_pend)
            chk({24'h0, irq_sel}, {24'h0, 1'b1, lowest(irq_pend), 3'd0}, "normal winner");
      end
      drive_pend('0, '0);
      $display("test nesting off done");

      // nesting on: level order, in-service set on vector read, blocking, then clear
      apb(1'b1, `SPR_A_ADDR, 32'h00007777);
      apb(1'b1, `SPR_B_ADDR, 32'h00000013);
      apb(1'b1, `NEST_CTRL_ADDR, 32'h00000001);
      drive_pend(14'h0031, '0);
      chk({24'h0, irq_sel}, {24'h0, 1'b1, 4'd5, 3'd1}, "level winner");
      apb(1'b0, `NORM_VEC_ADDR, 32'h0);
      chk(rd, 32'h80000029, "vector value");
      drive_pend(14'h0031, '0);
      chk({24'h0, in_service}, 32'h2, "in service set");
      chk({31'h0, irq_out}, 32'h0, "blocked levels");
      apb(1'b1, `SPR_A_ADDR, 32'h00000000);
      drive_pend(14'h0031, '0);
      chk({24'h0, irq_sel}, {24'h0, 1'b1, 4'd0, 3'd0}, "higher level passes");
      apb(1'b1, `NORM_INSV_ADDR, 32'hffffffff);
      drive_pend(14'h0030, '0);
      chk({24'h0, in_service}, 32'h0, "in service cleared");
      chk({24'h0, irq_sel}, {24'h0, 1'b1, 4'd5, 3'd1}, "unblocked winner");
      $display("test nesting on done");

      // fast class nesting, clear needs its own bit in the data, fast vector with nesting off
      apb(1'b1, `NEST_CTRL_ADDR, 32'h00000003);
      apb(1'b0, `NEST_CTRL_ADDR, 32'h0);
      chk(rd, 32'h3, "nesting control readback");
      drive_pend(14'h0030, 14'h0030);
      chk({31'h0, fiq_out}, 32'h1, "fast out nested");
      chk({31'h0, irq_out}, 32'h0, "normal held by fast");
      apb(1'b0, `FAST_VEC_ADDR, 32'h0);
      chk(rd, 32'h80000029, "fast vector level winner");
      chk({24'h0, in_service}, 32'h0, "fast read keeps in service");
      apb(1'b0, `NORM_VEC_ADDR, 32'h0);
      chk(rd, 32'h80000029, "normal vector again");
      apb(1'b1, `NORM_INSV_ADDR, 32'hfffffffd);
      chk({24'h0, in_service}, 32'h2, "clear needs own bit");
      apb(1'b1, `NORM_INSV_ADDR, 32'h00000002);
      chk({24'h0, in_service}, 32'h0, "own bit clears");
      apb(1'b1, `NEST_CTRL_ADDR, 32'h0);
      apb(1'b0, `FAST_VEC_ADDR, 32'h0);
      chk(rd, 32'h80000020, "fast vector nesting off");
      drive_pend('0, '0);
      $display("test fast class done");
      final_report();
   end
endmodule : irq_source_priority_regs_bench
